/* File: design/lbhls_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - drive bus lock low when a lock prefix asks for it
// - lock starts at first data cycle after prefix, ends when instruction completes
// - no prefetch cycles while lock is asserted
// - lock floats during hold grant and during reset
// - three active-low status outputs encode the bus cycle started
// - raise hold ack and float bus and control outputs together
// - drop hold ack when hold request is seen low
// - drive bus again only when the next bus cycle is run
// - enhanced mode: drop hold ack when refresh pends under hold
// - upper select low for memory accesses in programmed upper block
// - upper select keeps driving during hold grant
// - lower select low for memory accesses in programmed lower block
// - sample both selects at reset release; both low enters float mode
// - float mode keeps every pin high impedance until next reset
module lbhls_top
    import lbhls_pkg::*;
(
    input  wire logic           clk_in,              // core clock, 25 MHz
    input  wire logic           reset_in,            // sync reset, high
    input  wire lbhls_cyc_req_t cyc_req_in,          // core bus cycle request
    input  wire logic           lock_prefix_in,      // lock prefix decoded, level
    input  wire logic           instr_done_in,       // instruction complete, pulse
    input  wire logic           refresh_pend_in,     // refresh pending, level
    input  wire lbhls_cfg_t     cfg_in,              // mode and region sizes
    input  wire logic           hold_req_in,         // hold request pin
    input  wire logic           upper_sel_pin_in,    // upper select pin level
    input  wire logic           lower_sel_pin_in,    // lower select pin level
    output var  logic           cyc_accept_out,      // request taken, pulse
    output var  logic           cyc_done_out,        // cycle finished, pulse
    output var  logic           bus_lock_n_out,      // lock pin value
    output var  logic           bus_lock_oe_n_out,   // lock pin enable, low drives
    output var  logic           cycle_status_bit0_n, // status bit 0 pin
    output var  logic           cycle_status_bit1_n, // status bit 1 pin
    output var  logic           cycle_status_bit2_n, // status bit 2 pin
    output var  logic           status_oe_n_out,     // status pins enable
    output var  logic [19:0]    ad_out,              // address/data bus value
    output var  logic           ad_oe_n_out,         // bus and control enable
    output var  logic           bus_grant_ack_out,   // hold acknowledge pin
    output var  logic           grant_ack_oe_n_out,  // hold ack enable
    output var  logic           upper_mem_select_n,  // upper select pin value
    output var  logic           upper_sel_oe_n_out,  // upper select enable
    output var  logic           lower_mem_select_n,  // lower select pin value
    output var  logic           lower_sel_oe_n_out,  // lower select enable
    output var  logic           all_pins_float_mode  // float test mode active
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [PIN_SYNC_W-1:0] pin_sync;

    lbhls_sync #(.WIDTH(PIN_SYNC_W)) u_sync
    (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in ({hold_req_in, upper_sel_pin_in, lower_sel_pin_in}),
        .sync_out (pin_sync)
    );

    wire hold_req_s  = pin_sync[2];
    wire upper_pin_s = pin_sync[1];
    wire lower_pin_s = pin_sync[0];

    // ****************************************************************
    // region decode
    // ****************************************************************
    function automatic logic [ADDR_W:0] region_bytes(input logic [SIZE_CODE_W-1:0] code);
        logic [SIZE_CODE_W-1:0] c;
        c = (code > SIZE_CODE_MAX) ? SIZE_CODE_MAX : code;
        // shift in two steps: a four-bit sum of code and kilobyte shift would wrap
        region_bytes = ((ADDR_W+1)'(1) << KB_SHIFT) << c;
    endfunction : region_bytes

    function automatic logic upper_hit(input logic [ADDR_W-1:0] a,
                                       input logic [SIZE_CODE_W-1:0] code);
        logic [ADDR_W:0] base;
        base = ((ADDR_W+1)'(1) << ADDR_W) - region_bytes(code);
        upper_hit = ({1'b0, a} >= base);
    endfunction : upper_hit

    function automatic logic lower_hit(input logic [ADDR_W-1:0] a,
                                       input logic [SIZE_CODE_W-1:0] code);
        lower_hit = ({1'b0, a} < region_bytes(code));
    endfunction : lower_hit

    // ****************************************************************
    // state
    // ****************************************************************
    lbhls_state_t   state_r, state_nxt;
    lbhls_cyc_req_t cur_r;
    logic           lock_armed_r;
    logic           lock_act_r;
    logic           float_mode_r;
    logic           reset_d_r;
    logic           driven_r;

    wire release_rel = reset_d_r && !reset_in;
    // the capture edge may itself enter float mode, so nothing starts there
    wire float_hold  = float_mode_r || release_rel;
    // lock blocks prefetch; data cycles still run under lock
    wire req_ok      = cyc_req_in.valid && !(cyc_req_in.prefetch && lock_act_r);
    // hold only granted between cycles with lock idle
    wire hold_ok     = hold_req_s && !lock_act_r && !lock_armed_r;
    wire idle_like   = (state_r == LBHLS_IDLE) || (state_r == LBHLS_T4);
    wire start_cyc   = idle_like && !hold_ok && req_ok && !float_hold;
    wire grant_now   = idle_like && hold_ok && !float_hold;
    wire lock_start  = start_cyc && lock_armed_r && !cyc_req_in.prefetch;
    wire refresh_ask = cfg_in.enhanced && refresh_pend_in;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            LBHLS_IDLE,
            LBHLS_T4:
            begin
                if (grant_now)
                    state_nxt = LBHLS_HOLD;
                else if (start_cyc)
                    state_nxt = LBHLS_T1;
                else
                    state_nxt = LBHLS_IDLE;
            end
            LBHLS_T1:   state_nxt = LBHLS_T2;
            LBHLS_T2:   state_nxt = LBHLS_T3;
            LBHLS_T3:   state_nxt = LBHLS_T4;
            LBHLS_HOLD:
            begin
                if (!hold_req_s)
                    state_nxt = LBHLS_IDLE;
                else if (refresh_ask)
                    state_nxt = LBHLS_BACK;
            end
            LBHLS_BACK:
            begin
                // wait for master to let go before the refresh runs
                if (!hold_req_s)
                    state_nxt = LBHLS_IDLE;
            end
            default:    state_nxt = LBHLS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            state_r <= LBHLS_IDLE;
        else
            state_r <= state_nxt;
    end

    // ****************************************************************
    // lock tracking
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            lock_armed_r <= 1'b0;
            lock_act_r   <= 1'b0;
        end
        else
        begin
            // a fresh prefix wins over the start that consumes the old one
            if (lock_prefix_in)
                lock_armed_r <= 1'b1;
            else if (lock_start)
                lock_armed_r <= 1'b0;
            if (lock_start)
                lock_act_r <= 1'b1;
            else if (instr_done_in && lock_act_r)
                lock_act_r <= 1'b0;
        end
    end

    // ****************************************************************
    // float test mode capture at reset release
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        reset_d_r <= reset_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (release_rel)
            float_mode_r <= !upper_pin_s && !lower_pin_s;
        else if (reset_in)
            float_mode_r <= 1'b0;
    end

    // ****************************************************************
    // current cycle and bus ownership
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            cur_r <= '0;
        else if (start_cyc)
            cur_r <= cyc_req_in;
    end

    // released bus stays floated until a cycle actually needs it
    always_ff @(posedge clk_in)
    begin
        if (reset_in || grant_now)
            driven_r <= 1'b0;
        else if (start_cyc)
            driven_r <= 1'b1;
    end

    // ****************************************************************
    // registered pin outputs
    // ****************************************************************
    wire in_cycle   = (state_nxt == LBHLS_T1) || (state_nxt == LBHLS_T2)
                   || (state_nxt == LBHLS_T3);
    wire nxt_start  = start_cyc;
    wire lbhls_drv  = (driven_r || nxt_start) && !grant_now && !float_mode_r
                   && !reset_in;
    wire [ADDR_W-1:0] nxt_addr = nxt_start ? cyc_req_in.addr : cur_r.addr;
    wire nxt_mem    = nxt_start ? cyc_req_in.is_mem : cur_r.is_mem;
    wire up_sel     = in_cycle && nxt_mem && upper_hit(nxt_addr, cfg_in.upper_size);
    wire lo_sel     = in_cycle && nxt_mem && lower_hit(nxt_addr, cfg_in.lower_size);
    wire ack_nxt    = (state_nxt == LBHLS_HOLD);
    wire lock_nxt   = lock_start || (lock_act_r && !(instr_done_in && !lock_start));
    wire sel_drive  = !reset_in && !float_mode_r;
    wire [STAT_W-1:0] stat_nxt = nxt_start ? cyc_req_in.status_n : STATUS_PASSIVE;

    // ****************************************************************
    // core handshake pulses
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        cyc_accept_out      <= !reset_in && start_cyc;
        cyc_done_out        <= !reset_in && (state_r == LBHLS_T3);
    end

    // ****************************************************************
    // lock pin
    // ****************************************************************
    // lock shares the bus enable, so hold and reset float it alike
    always_ff @(posedge clk_in)
    begin
        bus_lock_n_out      <= !lock_nxt;
        bus_lock_oe_n_out   <= !lbhls_drv;
    end

    // ****************************************************************
    // cycle status pins
    // ****************************************************************
    // code stands for the first clock only, passive afterwards
    always_ff @(posedge clk_in)
    begin
        cycle_status_bit0_n <= stat_nxt[0];
        cycle_status_bit1_n <= stat_nxt[1];
        cycle_status_bit2_n <= stat_nxt[2];
        status_oe_n_out     <= !lbhls_drv;
    end

    // ****************************************************************
    // address/data bus
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        ad_out              <= nxt_addr;
        ad_oe_n_out         <= !lbhls_drv;
    end

    // ****************************************************************
    // hold acknowledge pin
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        bus_grant_ack_out   <= !reset_in && ack_nxt;
        grant_ack_oe_n_out  <= reset_in || float_mode_r;
    end

    // ****************************************************************
    // memory selects
    // ****************************************************************
    // selects ignore hold; only reset and float mode release them
    always_ff @(posedge clk_in)
    begin
        upper_mem_select_n  <= !up_sel;
        upper_sel_oe_n_out  <= !sel_drive;
        lower_mem_select_n  <= !lo_sel;
        lower_sel_oe_n_out  <= !sel_drive;
    end

    // ****************************************************************
    // float mode flag
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        all_pins_float_mode <= !reset_in && float_mode_r;
    end

endmodule : lbhls_top
`default_nettype wire

/* File: design/lbhls_pkg.sv */
// ****************************************************************
// local bus hold / lock / select constants and types
// ****************************************************************
package lbhls_pkg;

    localparam int          ADDR_W          = 20;
    localparam int          STAT_W          = 3;
    localparam int          SIZE_CODE_W     = 4;
    localparam int          KB_SHIFT        = 10;
    localparam logic [3:0]  SIZE_CODE_MAX   = 4'h8;
    localparam logic [2:0]  STATUS_PASSIVE  = 3'h7;
    localparam int          SYNC_STAGES     = 2;
    localparam int          PIN_SYNC_W      = 3;

    typedef enum logic [2:0]
    {
        LBHLS_IDLE = 3'b000,
        LBHLS_T1   = 3'b001,
        LBHLS_T2   = 3'b010,
        LBHLS_T3   = 3'b011,
        LBHLS_T4   = 3'b100,
        LBHLS_HOLD = 3'b101,
        LBHLS_BACK = 3'b110
    } lbhls_state_t;

    typedef struct packed
    {
        logic                valid;
        logic                prefetch;
        logic                is_mem;
        logic [STAT_W-1:0]   status_n;
        logic [ADDR_W-1:0]   addr;
    } lbhls_cyc_req_t;

    typedef struct packed
    {
        logic                   enhanced;
        logic [SIZE_CODE_W-1:0] upper_size;
        logic [SIZE_CODE_W-1:0] lower_size;
    } lbhls_cfg_t;

endpackage : lbhls_pkg

/* File: design/lbhls_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-stage synchroniser for pin inputs
// ****************************************************************
module lbhls_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_in,     // core clock
    input  wire logic             reset_in,   // sync reset, high
    input  wire logic [WIDTH-1:0] async_in,   // raw pin levels
    output var  logic [WIDTH-1:0] sync_out    // synchronised levels
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk_in)
    begin
        meta_r   <= async_in;
        sync_out <= meta_r;
    end

endmodule : lbhls_sync
`default_nettype wire

/* File: testbench/lbhls_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module lbhls_asserts
    import lbhls_pkg::*;
(
    input wire logic           clk_in,              // clock
    input wire logic           reset_in,            // reset
    input wire lbhls_cyc_req_t cyc_req_in,          // request
    input wire logic           instr_done_in,       // done pulse
    input wire logic           refresh_pend_in,     // refresh
    input wire lbhls_cfg_t     cfg_in,              // mode
    input wire logic           hold_req_in,         // hold pin
    input wire logic           cyc_accept_out,      // accept
    input wire logic           bus_lock_n_out,      // lock
    input wire logic           bus_lock_oe_n_out,   // lock enable
    input wire logic           cycle_status_bit0_n, // status 0
    input wire logic           cycle_status_bit1_n, // status 1
    input wire logic           cycle_status_bit2_n, // status 2
    input wire logic           status_oe_n_out,     // status enable
    input wire logic           ad_oe_n_out,         // bus enable
    input wire logic           bus_grant_ack_out,   // ack
    input wire logic           upper_sel_oe_n_out,  // upper enable
    input wire logic           lower_sel_oe_n_out,  // lower enable
    input wire logic           all_pins_float_mode  // float mode
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire [2:0] stat_n = {cycle_status_bit2_n, cycle_status_bit1_n, cycle_status_bit0_n};
    wire       lk_on  = !bus_lock_n_out && !bus_lock_oe_n_out;

    property p_lk_start; $rose(lk_on) |-> cyc_accept_out; endproperty
    a_lk_start: assert property (p_lk_start) else $error("lock not at cycle");
    property p_no_pf;
        lk_on && !instr_done_in && !$past(instr_done_in) && cyc_req_in.valid
            && cyc_req_in.prefetch |=> !cyc_accept_out;
    endproperty
    a_no_pf: assert property (p_no_pf) else $error("prefetch under lock");
    property p_lk_float; bus_grant_ack_out |-> bus_lock_oe_n_out; endproperty
    a_lk_float: assert property (p_lk_float) else $error("lock driven in hold");
    property p_stat;
        cyc_accept_out |-> !status_oe_n_out && stat_n == $past(cyc_req_in.status_n)
            ##1 stat_n == STATUS_PASSIVE;
    endproperty
    a_stat: assert property (p_stat) else $error("status code wrong");
    property p_grant;
        $rose(bus_grant_ack_out) |-> ad_oe_n_out && status_oe_n_out && $past(hold_req_in, 2);
    endproperty
    a_grant: assert property (p_grant) else $error("grant without float");
    property p_ack_drop; !hold_req_in [*3] |=> !bus_grant_ack_out; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack kept");
    property p_resume; $fell(ad_oe_n_out) |-> cyc_accept_out; endproperty
    a_resume: assert property (p_resume) else $error("bus driven idle");
    property p_rfsh;
        cfg_in.enhanced && refresh_pend_in && bus_grant_ack_out |-> ##[1:4] !bus_grant_ack_out;
    endproperty
    a_rfsh: assert property (p_rfsh) else $error("refresh ack kept");
    property p_sel_hold; bus_grant_ack_out |-> !upper_sel_oe_n_out && !lower_sel_oe_n_out;
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select floated");
    property p_float;
        all_pins_float_mode |-> ad_oe_n_out && status_oe_n_out && bus_lock_oe_n_out
            && upper_sel_oe_n_out && lower_sel_oe_n_out;
    endproperty
    a_float: assert property (p_float) else $error("pin driven in float");
    property p_no_lk_grant; $rose(bus_grant_ack_out) |-> !$past(lk_on); endproperty
    a_no_lk_grant: assert property (p_no_lk_grant) else $error("grant in lock");
    c_grant: cover property ($rose(bus_grant_ack_out));
    c_lock: cover property (lk_on);
    c_float: cover property (all_pins_float_mode);
endmodule : lbhls_asserts
`default_nettype wire

/* File: testbench/lbhls_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// external master asking for the bus
// ****
module lbhls_master_model
(
    input  wire logic clk_in,      // clock
    input  wire logic want_in,     // bench wants the bus
    input  wire logic ack_in,      // grant ack pin
    output var  logic hold_req_out // hold request pin
);
    logic got_r;
    // once granted and taken back, stay off until no longer wanted
    always_ff @(posedge clk_in)
    begin
        got_r        <= want_in && (got_r || ack_in);
        hold_req_out <= want_in && !(got_r && !ack_in);
    end
endmodule : lbhls_master_model
`default_nettype wire

/* File: testbench/local_bus_hold_lock_select_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module local_bus_hold_lock_select_bench;
    import lbhls_pkg::*;
    logic clk_in = 1'h0, reset_in = 1'h1, lock_prefix_in = 1'h0, instr_done_in = 1'h0;
    logic refresh_pend_in = 1'h0, upper_sel_pin_in = 1'h1, lower_sel_pin_in = 1'h1, want = 1'h0;
    logic hold_req_in, cyc_accept_out, cyc_done_out, bus_lock_n_out, bus_lock_oe_n_out;
    logic cycle_status_bit0_n, cycle_status_bit1_n, cycle_status_bit2_n, status_oe_n_out;
    logic ad_oe_n_out, bus_grant_ack_out, grant_ack_oe_n_out, upper_mem_select_n;
    logic upper_sel_oe_n_out, lower_mem_select_n, lower_sel_oe_n_out, all_pins_float_mode;
    logic [19:0]    ad_out;
    lbhls_cyc_req_t cyc_req_in = '0;
    lbhls_cfg_t     cfg_in = '0;
    int             errors = 0;
    int             cmp_count = 0;

    always #20 clk_in = ~clk_in;
    lbhls_top i_lbhls_top (.*);
    lbhls_master_model i_lbhls_master_model (.clk_in(clk_in), .want_in(want),
        .ack_in(bus_grant_ack_out), .hold_req_out(hold_req_in));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
            begin
                errors++;
                $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
            end
    endtask : chk

    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    function automatic logic [1:0] sel_exp(input lbhls_cyc_req_t r, input lbhls_cfg_t c);
        logic [20:0] ub;
        logic [20:0] lb;
        ub = 21'h400 << ((c.upper_size > 4'h8) ? 4'h8 : c.upper_size);
        lb = 21'h400 << ((c.lower_size > 4'h8) ? 4'h8 : c.lower_size);
        return {!(r.is_mem && r.addr >= 21'h100000 - ub), !(r.is_mem && r.addr < lb)};
    endfunction : sel_exp

    task automatic run_cyc(input lbhls_cyc_req_t r, output bit got, output logic lk);
        got = 0;
        cyc_req_in <= r;
        repeat (12)
        begin
            @(posedge clk_in);
            if (cyc_accept_out === 1'h1)
            begin
                got = 1;
                break;
            end
        end
        lk = bus_lock_n_out;
        cyc_req_in <= '0;
        if (got)
        begin
            chk("status", r.status_n, {cycle_status_bit2_n, cycle_status_bit1_n, cycle_status_bit0_n});
            chk("selects", sel_exp(r, cfg_in), {upper_mem_select_n, lower_mem_select_n});
            chk("address", {1'h0, r.addr}, {ad_oe_n_out, ad_out});
            repeat (3) @(posedge clk_in);
            chk("done", 1, cyc_done_out);
        end
    endtask : run_cyc

    task automatic wait_ack(input logic v);
        repeat (12)
        begin
            @(posedge clk_in);
            if (bus_grant_ack_out === v)
                break;
        end
    endtask : wait_ack

    task automatic do_reset(input logic u, input logic l);
        reset_in <= 1'h1;
        upper_sel_pin_in <= u;
        lower_sel_pin_in <= l;
        repeat (10) @(posedge clk_in);
        chk("lock oe reset", 1, bus_lock_oe_n_out);
        reset_in <= 1'h0;
        repeat (3) @(posedge clk_in);
        upper_sel_pin_in <= 1'h1;
        lower_sel_pin_in <= 1'h1;
        chk("float mode", !(u || l), all_pins_float_mode);
        chk("ack oe", !(u || l), grant_ack_oe_n_out);
        chk("sel oe", {2{!(u || l)}}, {upper_sel_oe_n_out, lower_sel_oe_n_out});
    endtask : do_reset

    initial
    begin
        repeat (5000) @(posedge clk_in);
        errors++;
        print_verdict();
    end

    initial
    begin
        bit             g;
        logic           lk;
        lbhls_cyc_req_t r;
        lbhls_cfg_t     c;
        void'($urandom(29));
        do_reset(1'h1, 1'h1);
        for (int i = 0; i < 30; i++)
        begin
            c = '{1'h0, 4'($urandom_range(0, 9)), 4'($urandom_range(0, 9))};
            r = '{1'h1, 1'h0, 1'($urandom), 3'($urandom), 20'($urandom)};
            // corner addresses sit on either side of a region edge, except for size code 9, which the design clamps to 8
            if (i % 3 == 1)
                r.addr = 20'((21'h400 << c.lower_size) - 21'(i % 2));
            if (i % 3 == 2)
                r.addr = 20'(21'h100000 - (21'h400 << c.upper_size) - 21'(i % 2));
            cfg_in <= c;
            run_cyc(r, g, lk);
            chk("taken", 1, g);
        end
        lock_prefix_in <= 1'h1;
        @(posedge clk_in);
        lock_prefix_in <= 1'h0;
        run_cyc(r, g, lk);
        chk("lock on", 0, lk);
        want <= 1'h1;
        r.prefetch = 1'h1;
        run_cyc(r, g, lk);
        chk("prefetch refused", 0, g);
        chk("no grant locked", 0, bus_grant_ack_out);
        instr_done_in <= 1'h1;
        @(posedge clk_in);
        instr_done_in <= 1'h0;
        wait_ack(1'h1);
        chk("ack", 1, bus_grant_ack_out);
        chk("bus float", 3, {ad_oe_n_out, bus_lock_oe_n_out});
        chk("upper driven", 0, upper_sel_oe_n_out);
        want <= 1'h0;
        wait_ack(1'h0);
        chk("ack drop", 0, bus_grant_ack_out);
        repeat (4) @(posedge clk_in);
        chk("still float", 1, ad_oe_n_out);
        run_cyc(r, g, lk);
        chk("lock off", 3, {g, lk});
        cfg_in.enhanced <= 1'h1;
        want <= 1'h1;
        wait_ack(1'h1);
        refresh_pend_in <= 1'h1;
        wait_ack(1'h0);
        chk("refresh ack", 0, bus_grant_ack_out);
        repeat (3) @(posedge clk_in);
        chk("hold released", 0, hold_req_in);
        want <= 1'h0;
        refresh_pend_in <= 1'h0;
        run_cyc(r, g, lk);
        chk("refresh cycle", 1, g);
        for (int k = 0; k < 3; k++)
        begin
            do_reset(k[1], k[0]);
            run_cyc(r, g, lk);
            chk("float refuse", k != 0, g);
        end
        print_verdict();
    end
endmodule : local_bus_hold_lock_select_bench
bind lbhls_top lbhls_asserts i_lbhls_asserts
(
    .clk_in              (clk_in),
    .reset_in            (reset_in),
    .cyc_req_in          (cyc_req_in),
    .instr_done_in       (instr_done_in),
    .refresh_pend_in     (refresh_pend_in),
    .cfg_in              (cfg_in),
    .hold_req_in         (hold_req_in),
    .cyc_accept_out      (cyc_accept_out),
    .bus_lock_n_out      (bus_lock_n_out),
    .bus_lock_oe_n_out   (bus_lock_oe_n_out),
    .cycle_status_bit0_n (cycle_status_bit0_n),
    .cycle_status_bit1_n (cycle_status_bit1_n),
    .cycle_status_bit2_n (cycle_status_bit2_n),
    .status_oe_n_out     (status_oe_n_out),
    .ad_oe_n_out         (ad_oe_n_out),
    .bus_grant_ack_out   (bus_grant_ack_out),
    .upper_sel_oe_n_out  (upper_sel_oe_n_out),
    .lower_sel_oe_n_out  (lower_sel_oe_n_out),
    .all_pins_float_mode (all_pins_float_mode)
);
`default_nettype wire
